// ---- include/ctm_pkg.sv ----
// ctm_pkg: register map, field layout and shared types of the
// counter/timer with match, capture and single-edge pwm.
// assumes a 32-bit classic wishbone register bus, byte addressed.
package ctm_pkg;

	// ******************************************************
	// sizes
	// ******************************************************
	localparam int CNT_W = 32;
	localparam int NUM_MAT = 4;
	localparam int NUM_CAP = 2;
	localparam int ADR_W = 8;

	// ******************************************************
	// register byte offsets
	// ******************************************************
	localparam logic [7:0] OFS_IR = 8'h00;
	localparam logic [7:0] OFS_TCR = 8'h04;
	localparam logic [7:0] OFS_TC = 8'h08;
	localparam logic [7:0] OFS_PR = 8'h0C;
	localparam logic [7:0] OFS_PC = 8'h10;
	localparam logic [7:0] OFS_MCR = 8'h14;
	localparam logic [7:0] OFS_MR0 = 8'h18;
	localparam logic [7:0] OFS_MR_STEP = 8'h04;
	localparam logic [7:0] OFS_CCR = 8'h28;
	localparam logic [7:0] OFS_CR0 = 8'h2C;
	localparam logic [7:0] OFS_CR1 = 8'h34;
	localparam logic [7:0] OFS_EMR = 8'h3C;
	localparam logic [7:0] OFS_CTCR = 8'h70;
	localparam logic [7:0] OFS_PWM_SELECT_REG = 8'h74;

	// ******************************************************
	// field positions
	// ******************************************************
	localparam int TCR_EN = 0;
	localparam int TCR_RST = 1;
	localparam int MCR_INT = 0;
	localparam int MCR_RST = 1;
	localparam int MCR_STOP = 2;
	localparam int MCR_STRIDE = 3;
	localparam int CCR_RISE = 0;
	localparam int CCR_FALL = 1;
	localparam int CCR_INT = 2;
	localparam int CCR_STRIDE = 3;
	localparam int IR_CAP0 = 4;
	localparam int IR_W = 8;
	localparam int EMR_CTL = 4;
	localparam int CTCR_SEL = 2;
	localparam int CTCR_CLR_EN = 4;
	localparam int CTCR_CLR_SEL = 5;
	localparam logic [1:0] MODE_TIMER = 2'h0;
	localparam logic [1:0] MODE_RISE = 2'h1;
	localparam logic [1:0] MODE_FALL = 2'h2;
	localparam logic [31:0] RST_VAL = 32'h0000_0000;

	// ******************************************************
	// types
	// ******************************************************
	typedef enum logic [1:0] {
		EM_NONE,
		EM_LOW,
		EM_HIGH,
		EM_TOGGLE
	} ctm_em_act_type;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [ADR_W-1:0] adr;
		logic [31:0] dat;
	} ctm_wb_req_type;

	typedef struct packed {
		logic pwm_en;
		ctm_em_act_type act;
	} ctm_chan_cfg_type;

endpackage

// ---- src/ctm_sync.sv ----
// ctm_sync: two-flop synchroniser for a bundle of pin inputs.
// assumes each bit is an independent asynchronous level.
`timescale 1ns/1ps
module ctm_sync #(
	parameter int W = 2
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= d_i;
			sync_q <= meta_q;
		end
	end

	assign q_o = sync_q;

endmodule

// ---- src/ctm_chan.sv ----
// ctm_chan: one match output, either single-edge pwm or external
// match action. assumes match_i and wrap_i are one-cycle pulses that
// come in step with the count they mark, with no clock of lag.
`timescale 1ns/1ps
module ctm_chan (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire ctm_pkg::ctm_chan_cfg_type cfg_i,
	input wire logic match_i,
	input wire logic wrap_i,
	input wire logic zero_i,
	input wire logic wr_i,
	input wire logic wr_val_i,
	output logic out_o
);

	logic out_q;

	// ******************************************************
	// output state
	// ******************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_q <= 1'b0;
		end else if (cfg_i.pwm_en) begin
			if (wrap_i) begin
				out_q <= zero_i;
			end else if (match_i && !zero_i) begin
				out_q <= 1'b1;
			end
		end else if (match_i) begin
			case (cfg_i.act)
				ctm_pkg::EM_LOW: begin
					out_q <= 1'b0;
				end
				ctm_pkg::EM_HIGH: begin
					out_q <= 1'b1;
				end
				ctm_pkg::EM_TOGGLE: begin
					out_q <= !out_q;
				end
				default: begin
					out_q <= out_q;
				end
			endcase
		end else if (wr_i) begin
			out_q <= wr_val_i;
		end
	end

	assign out_o = out_q;

	// ******************************************************
	// checks
	// ******************************************************
	property p_pwm_low;
		@(posedge clk_i) disable iff (rst_i)
		cfg_i.pwm_en && wrap_i && !zero_i |=> !out_q;
	endproperty
	a_pwm_low: assert property (p_pwm_low) else $error("pwm not low");

	property p_pwm_high;
		@(posedge clk_i) disable iff (rst_i)
		cfg_i.pwm_en && match_i && !wrap_i && !zero_i |=> out_q;
	endproperty
	a_pwm_high: assert property (p_pwm_high) else $error("pwm not set");

	property p_pwm_zero;
		@(posedge clk_i) disable iff (rst_i)
		cfg_i.pwm_en && wrap_i && zero_i |=> out_q;
	endproperty
	a_pwm_zero: assert property (p_pwm_zero) else $error("zero not high");

	property p_em_toggle;
		@(posedge clk_i) disable iff (rst_i)
		!cfg_i.pwm_en && match_i && cfg_i.act == ctm_pkg::EM_TOGGLE
		|=> out_q != $past(out_q);
	endproperty
	a_em_toggle: assert property (p_em_toggle) else $error("no toggle");

	property p_pwm_pulse;
		@(posedge clk_i) disable iff (rst_i)
		cfg_i.pwm_en && !out_q ##1 out_q ##1 !out_q;
	endproperty
	c_pwm_pulse: cover property (p_pwm_pulse);

endmodule

// ---- src/ctm_timer.sv ----
// ctm_timer: 32-bit counter/timer with prescaler, four match channels,
// capture inputs and single-edge pwm, behind a classic wishbone slave.
// assumes cap_i are asynchronous pins; the bus runs on clk_i.
//
// Contract
// - pwm outputs drop at cycle start unless zero
// - pwm output rises when count hits match
// - oversized match clears high output next cycle
// - match equal cycle length gives one-tick pulse
// - zero match goes high at wrap, stays
// - reset on match at end of cycle
// - match flag rises the clock after match
// - stop on match clears enable, flags match
// - 32-bit count through 32-bit prescaler
// - count clock cycles or capture input edges
// - capture edge loads count into capture register
// - capture event may clear count and prescaler
// - four match registers: continue, stop, reset
// - match output low, high, toggle or hold
// - three pwm channels, one sets cycle length
// - per output choice of pwm or match
// - prescaler wraps at limit, then count increments
// - flag register read pending, write one clears
//
// The address map and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
module ctm_timer #(
	parameter int CNT_W = ctm_pkg::CNT_W,
	parameter int NUM_CAP = ctm_pkg::NUM_CAP
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire ctm_pkg::ctm_wb_req_type wb_req_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [NUM_CAP-1:0] cap_i,
	output logic [ctm_pkg::NUM_MAT-1:0] mat_o
);

	localparam int NM = ctm_pkg::NUM_MAT;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	if (CNT_W < 1 || CNT_W > 32 || NUM_CAP < 1 || NUM_CAP > 2) begin : g_chk
		$error("ctm_timer: unsupported CNT_W or NUM_CAP");
	end

	logic req_w, wr_w, ack_q;
	logic [7:0] adr_w;
	logic [31:0] dat_q, rd_w, bmask_w, wv_w;
	logic [1:0] tcr_q;
	logic [CNT_W-1:0] tc_q, pc_q, pr_q;
	logic [CNT_W-1:0] mr_q [NM];
	logic [CNT_W-1:0] cr_q [NUM_CAP];
	logic [ctm_pkg::MCR_STRIDE*NM-1:0] mcr_q;
	logic [ctm_pkg::CCR_STRIDE*NUM_CAP-1:0] ccr_q;
	logic [2*NM-1:0] emc_q;
	logic [7:0] ctcr_q;
	logic [NM-1:0] pwm_select_reg_q;
	logic [ctm_pkg::IR_W-1:0] ir_q, set_w;
	logic [NM-1:0] eq_w, hit_q, mevt_w, mint_w, stop_w, rst_hit_w, mat_w;
	logic [NUM_CAP-1:0] cap_s, prev_q, rise_w, fall_w, capt_w, cirq_w;
	logic [1:0] rise2_w, fall2_w, csel_w;
	logic [2:0] clr_sel_w;
	logic en_w, edge_w, tick_w, roll_w, cclr_w, clr_w, wrap_w, wrap_q;

	function automatic logic wr_hit(input logic [7:0] ofs);
		return wr_w && adr_w == ofs;
	endfunction

	// ******************************************************
	// wishbone slave
	// ******************************************************
	assign req_w = wb_req_i.cyc & wb_req_i.stb;
	assign adr_w = {wb_req_i.adr[7:2], 2'b00};
	assign wr_w = req_w & wb_req_i.we & ack_q;

	always_comb begin
		for (int b = 0; b < 4; b++) begin
			bmask_w[8*b +: 8] = {8{wb_req_i.sel[b]}};
		end
	end

	assign wv_w = (rd_w & ~bmask_w) | (wb_req_i.dat & bmask_w);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= ctm_pkg::RST_VAL;
		end else begin
			ack_q <= req_w & ~ack_q;
			if (req_w && !ack_q) begin
				dat_q <= rd_w;
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	always_comb begin
		rd_w = 32'h0000_0000;
		case (adr_w)
			ctm_pkg::OFS_IR: rd_w = 32'(ir_q);
			ctm_pkg::OFS_TCR: rd_w = 32'(tcr_q);
			ctm_pkg::OFS_TC: rd_w = 32'(tc_q);
			ctm_pkg::OFS_PR: rd_w = 32'(pr_q);
			ctm_pkg::OFS_PC: rd_w = 32'(pc_q);
			ctm_pkg::OFS_MCR: rd_w = 32'(mcr_q);
			ctm_pkg::OFS_CCR: rd_w = 32'(ccr_q);
			ctm_pkg::OFS_CR0: rd_w = 32'(cr_q[0]);
			ctm_pkg::OFS_CR1: rd_w = 32'(cr_q[NUM_CAP-1]) & {32{NUM_CAP > 1}};
			ctm_pkg::OFS_EMR: rd_w = 32'({emc_q, mat_w});
			ctm_pkg::OFS_CTCR: rd_w = 32'(ctcr_q);
			ctm_pkg::OFS_PWM_SELECT_REG: rd_w = 32'(pwm_select_reg_q);
			default: rd_w = 32'h0000_0000;
		endcase
		for (int n = 0; n < NM; n++) begin
			if (adr_w == ctm_pkg::OFS_MR0 + 8'(n * 4)) begin
				rd_w = 32'(mr_q[n]);
			end
		end
	end

	// ******************************************************
	// configuration registers
	// ******************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tcr_q <= '0;
		end else if (|stop_w) begin
			tcr_q[ctm_pkg::TCR_EN] <= 1'b0;
		end else if (wr_hit(ctm_pkg::OFS_TCR)) begin
			tcr_q <= wv_w[1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pr_q <= '0;
			mcr_q <= '0;
			ccr_q <= '0;
			emc_q <= '0;
			ctcr_q <= '0;
			pwm_select_reg_q <= '0;
		end else begin
			if (wr_hit(ctm_pkg::OFS_PR)) pr_q <= wv_w[CNT_W-1:0];
			if (wr_hit(ctm_pkg::OFS_MCR)) mcr_q <= wv_w[$bits(mcr_q)-1:0];
			if (wr_hit(ctm_pkg::OFS_CCR)) ccr_q <= wv_w[$bits(ccr_q)-1:0];
			if (wr_hit(ctm_pkg::OFS_EMR)) begin
				emc_q <= wv_w[ctm_pkg::EMR_CTL +: 2*NM];
			end
			if (wr_hit(ctm_pkg::OFS_CTCR)) ctcr_q <= wv_w[7:0];
			if (wr_hit(ctm_pkg::OFS_PWM_SELECT_REG)) pwm_select_reg_q <= wv_w[NM-1:0];
		end
	end

	// ******************************************************
	// count source and prescaler
	// ******************************************************
	ctm_sync #(
		.W(NUM_CAP)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(cap_i),
		.q_o(cap_s)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev_q <= '0;
		end else begin
			prev_q <= cap_s;
		end
	end

	assign rise_w = cap_s & ~prev_q;
	assign fall_w = ~cap_s & prev_q;

	always_comb begin
		rise2_w = '0;
		fall2_w = '0;
		rise2_w[NUM_CAP-1:0] = rise_w;
		fall2_w[NUM_CAP-1:0] = fall_w;
		csel_w = ctcr_q[ctm_pkg::CTCR_SEL +: 2];
		clr_sel_w = ctcr_q[ctm_pkg::CTCR_CLR_SEL +: 3];
		case (ctcr_q[1:0])
			ctm_pkg::MODE_TIMER: edge_w = 1'b1;
			ctm_pkg::MODE_RISE: edge_w = !csel_w[1] && rise2_w[csel_w[0]];
			ctm_pkg::MODE_FALL: edge_w = !csel_w[1] && fall2_w[csel_w[0]];
			default: edge_w = !csel_w[1]
				&& (rise2_w[csel_w[0]] || fall2_w[csel_w[0]]);
		endcase
		cclr_w = ctcr_q[ctm_pkg::CTCR_CLR_EN] && !clr_sel_w[2]
			&& (clr_sel_w[0] ? fall2_w[clr_sel_w[1]]
			: rise2_w[clr_sel_w[1]]);
	end

	assign en_w = tcr_q[ctm_pkg::TCR_EN] & ~tcr_q[ctm_pkg::TCR_RST];
	assign tick_w = en_w & edge_w;
	assign roll_w = tick_w && pc_q == pr_q;
	assign clr_w = tcr_q[ctm_pkg::TCR_RST] | cclr_w;
	assign wrap_w = clr_w | (roll_w & (|rst_hit_w) & ~(|stop_w));

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc_q <= '0;
		end else if (clr_w) begin
			pc_q <= '0;
		end else if (wr_hit(ctm_pkg::OFS_PC)) begin
			pc_q <= wv_w[CNT_W-1:0];
		end else if (tick_w && !(|stop_w)) begin
			pc_q <= roll_w ? '0 : pc_q + CNT_W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tc_q <= '0;
		end else if (clr_w) begin
			tc_q <= '0;
		end else if (wr_hit(ctm_pkg::OFS_TC)) begin
			tc_q <= wv_w[CNT_W-1:0];
		end else if (roll_w && !(|stop_w)) begin
			tc_q <= (|rst_hit_w) ? '0 : tc_q + CNT_W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wrap_q <= 1'b0;
		end else begin
			wrap_q <= wrap_w;
		end
	end

	// ******************************************************
	// match channels
	// ******************************************************
	for (genvar n = 0; n < NM; n++) begin : g_mat
		localparam int B = n * ctm_pkg::MCR_STRIDE;
		ctm_pkg::ctm_chan_cfg_type cfg_w;

		assign eq_w[n] = tc_q == mr_q[n];
		assign mevt_w[n] = en_w & eq_w[n] & ~hit_q[n];
		assign mint_w[n] = mcr_q[B + ctm_pkg::MCR_INT];
		assign stop_w[n] = mevt_w[n] & mcr_q[B + ctm_pkg::MCR_STOP];
		assign rst_hit_w[n] = eq_w[n] & mcr_q[B + ctm_pkg::MCR_RST];
		assign cfg_w.pwm_en = pwm_select_reg_q[n];
		assign cfg_w.act = ctm_pkg::ctm_em_act_type'(emc_q[2*n +: 2]);

		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				mr_q[n] <= '0;
				hit_q[n] <= 1'b0;
			end else begin
				hit_q[n] <= en_w & eq_w[n];
				if (wr_hit(ctm_pkg::OFS_MR0 + 8'(n * 4))) begin
					mr_q[n] <= wv_w[CNT_W-1:0];
				end
			end
		end

		ctm_chan u_chan (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.cfg_i(cfg_w),
			.match_i(mevt_w[n]),
			.wrap_i(wrap_q),
			.zero_i(mr_q[n] == '0),
			.wr_i(wr_hit(ctm_pkg::OFS_EMR)),
			.wr_val_i(wv_w[n]),
			.out_o(mat_w[n])
		);
	end

	assign mat_o = mat_w;

	// ******************************************************
	// capture channels and flags
	// ******************************************************
	for (genvar i = 0; i < NUM_CAP; i++) begin : g_cap
		localparam int B = i * ctm_pkg::CCR_STRIDE;

		assign capt_w[i] = (rise_w[i] & ccr_q[B + ctm_pkg::CCR_RISE])
			| (fall_w[i] & ccr_q[B + ctm_pkg::CCR_FALL]);
		assign cirq_w[i] = capt_w[i] & ccr_q[B + ctm_pkg::CCR_INT];

		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				cr_q[i] <= '0;
			end else if (capt_w[i]) begin
				cr_q[i] <= tc_q;
			end
		end
	end

	always_comb begin
		set_w = '0;
		set_w[NM-1:0] = mevt_w & mint_w;
		set_w[ctm_pkg::IR_CAP0 +: NUM_CAP] = cirq_w;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ir_q <= '0;
		end else if (wr_hit(ctm_pkg::OFS_IR)) begin
			ir_q <= (ir_q & ~(wb_req_i.dat[7:0] & bmask_w[7:0]))
				| set_w;
		end else begin
			ir_q <= ir_q | set_w;
		end
	end

	// ******************************************************
	// checks
	// ******************************************************
	logic quiet_w;
	assign quiet_w = ctcr_q[1:0] == ctm_pkg::MODE_TIMER && en_w && !clr_w
		&& !wr_w && !(|stop_w);

	property p_match_flag;
		(|set_w[NM-1:0]) |=> (ir_q[NM-1:0] & $past(set_w[NM-1:0]))
			== $past(set_w[NM-1:0]);
	endproperty
	a_match_flag: assert property (p_match_flag) else $error("flag lost");

	property p_stop;
		(|stop_w) |=> !tcr_q[ctm_pkg::TCR_EN] && tc_q == $past(tc_q)
			&& (ir_q[NM-1:0] & $past(stop_w & mint_w)) == $past(stop_w & mint_w);
	endproperty
	a_stop: assert property (p_stop) else $error("stop failed");

	property p_pc_step;
		quiet_w && pc_q != pr_q |=> pc_q == $past(pc_q) + CNT_W'(1)
			&& tc_q == $past(tc_q);
	endproperty
	a_pc_step: assert property (p_pc_step) else $error("bad prescale");

	property p_tc_step;
		quiet_w && roll_w && !(|rst_hit_w) |=> tc_q == $past(tc_q) + CNT_W'(1)
			&& pc_q == '0;
	endproperty
	a_tc_step: assert property (p_tc_step) else $error("bad count");

	property p_rst_match;
		quiet_w && roll_w && (|rst_hit_w) |=> tc_q == '0 && pc_q == '0
			&& wrap_q;
	endproperty
	a_rst_match: assert property (p_rst_match) else $error("no reset");

	property p_capture;
		capt_w[0] |=> cr_q[0] == $past(tc_q);
	endproperty
	a_capture: assert property (p_capture) else $error("bad capture");

	property p_cap_clear;
		cclr_w |=> tc_q == '0 && pc_q == '0;
	endproperty
	a_cap_clear: assert property (p_cap_clear) else $error("no clear");

	property p_ir_clear;
		wr_hit(ctm_pkg::OFS_IR) && wb_req_i.dat[0] && bmask_w[0] && !set_w[0]
			|=> !ir_q[0];
	endproperty
	a_ir_clear: assert property (p_ir_clear) else $error("no clear");

	property p_ack_one;
		ack_q |=> !ack_q;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack stuck");

	c_stop: cover property (|stop_w);
	c_wrap: cover property (quiet_w && roll_w && (|rst_hit_w));
	c_cclr: cover property (cclr_w);

endmodule

// ---- verif/ctm_pin_model.sv ----
// ctm_pin_model: outside source that drives the two capture pins.
// assumes go_i is a one-cycle pulse and the lengths are held meanwhile.
`timescale 1ns/1ps
module ctm_pin_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic go_i,
	input wire logic sel_i,
	input wire logic [7:0] hi_len_i,
	input wire logic [7:0] lo_len_i,
	input wire logic [7:0] num_i,
	output logic busy_o,
	output logic [1:0] cap_o
);
	logic [7:0] left_q;
	logic [7:0] tick_q;
	logic sel_q;

	assign busy_o = (left_q != 8'h00);

	// pulse train: high then low, repeated; idle pins rest low
	always @(posedge clk_i) begin
		if (rst_i) begin
			left_q <= 8'h00;
			tick_q <= 8'h00;
			sel_q <= 1'b0;
			cap_o <= 2'h0;
		end else if (go_i && left_q == 8'h00) begin
			left_q <= num_i;
			sel_q <= sel_i;
			tick_q <= 8'h00;
		end else if (left_q != 8'h00) begin
			cap_o <= (tick_q < hi_len_i) ? (2'h1 << sel_q) : 2'h0;
			if (tick_q == hi_len_i + lo_len_i - 8'h01) begin
				tick_q <= 8'h00;
				left_q <= left_q - 8'h01;
			end else begin
				tick_q <= tick_q + 8'h01;
			end
		end else begin
			cap_o <= 2'h0;
		end
	end
endmodule

// ---- verif/ctm_timer_tb.sv ----
// ctm_timer_tb: self-checking bench for the counter/timer.
// assumes the wishbone answer one cycle after the request is seen.
`timescale 1ns/1ps
module ctm_timer_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	ctm_pkg::ctm_wb_req_type wb_req = '0;
	logic [31:0] wb_dat;
	logic wb_ack;
	logic [1:0] cap;
	logic [3:0] mat;
	logic go = 1'b0;
	logic sel = 1'b0;
	logic [7:0] hi = 8'h04;
	logic [7:0] lo = 8'h04;
	logic [7:0] num = 8'h01;
	logic busy;
	int err_count = 0;
	int compares = 0;
	int cyc_cnt = 0;
	int hc [4];
	logic [31:0] d;
	int pr, mr, g, w, n, len, m;

	ctm_timer ctm_timer_i (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req),
		.wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .cap_i(cap), .mat_o(mat));
	ctm_pin_model ctm_pin_model_i (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
		.sel_i(sel), .hi_len_i(hi), .lo_len_i(lo), .num_i(num),
		.busy_o(busy), .cap_o(cap));

	always #2.5 clk_i = ~clk_i;

	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 60000) begin
			err_count++;
			tally_and_finish();
		end
	end

	// ******************************************************
	// shared tasks
	// ******************************************************
	task automatic tally_and_finish();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic xfer(input logic we, input logic [7:0] a,
		input logic [31:0] v);
		int k;
		k = 0;
		@(posedge clk_i);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: v};
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack !== 1'b1 && k < 50);
		if (k >= 50) begin
			check(32'h0, 32'h1);
			tally_and_finish();
		end
		d = wb_dat;
		wb_req <= '0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		xfer(1'b1, a, v);
	endtask

	task automatic rd(input logic [7:0] a);
		xfer(1'b0, a, 32'h0);
	endtask

	task automatic restart(input logic [31:0] match_control_reg, input logic [31:0] p);
		wr(ctm_pkg::OFS_TCR, 32'h0000_0002);
		wr(ctm_pkg::OFS_MCR, match_control_reg);
		wr(ctm_pkg::OFS_PR, p);
		wr(ctm_pkg::OFS_IR, 32'h0000_00FF);
	endtask

	task automatic wait_cycles(input int c);
		repeat (c) @(posedge clk_i);
	endtask

	task automatic count_hi(input int c);
		hc = '{0, 0, 0, 0};
		repeat (c) begin
			@(posedge clk_i);
			for (int i = 0; i < 4; i++) hc[i] += (mat[i] === 1'b1);
		end
	endtask

	task automatic pulses(input logic s, input int h, input int l, input int k);
		int t;
		t = 0;
		@(posedge clk_i);
		sel <= s;
		hi <= 8'(h);
		lo <= 8'(l);
		num <= 8'(k);
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		do begin
			@(posedge clk_i);
			t++;
		end while ((busy === 1'b1 || t < 3) && t < 5000);
		wait_cycles(6);
	endtask

	function automatic logic emr_exp(input int act, input logic init);
		case (act)
			1: return 1'b0;
			2: return 1'b1;
			3: return ~init;
			default: return init;
		endcase
	endfunction

	// ******************************************************
	// main sequence
	// ******************************************************
	initial begin
		void'($urandom(19012));
		wait_cycles(12);
		rst_i <= 1'b0;
		for (int a = 0; a < 8'h78; a += 4) begin
			rd(8'(a));
			check(d, 32'h0);
		end
		wr(8'h40, 32'hFFFF_FFFF);
		rd(8'h40);
		check(d, 32'h0);
		// prescaler and reset-on-match give the toggle period
		for (int i = 0; i < 3; i++) begin
			pr = (i == 0) ? 2 : $urandom_range(0, 3);
			mr = (i == 0) ? 6 : $urandom_range(2, 9);
			restart(32'h0000_0003, pr);
			wr(ctm_pkg::OFS_MR0, mr);
			wr(ctm_pkg::OFS_EMR, 32'h0000_0030);
			wr(ctm_pkg::OFS_TCR, 32'h0000_0001);
			wait_cycles((mr + 1) * (pr + 1) + 4);
			count_hi(4 * (mr + 1) * (pr + 1));
			check(hc[0], 2 * (mr + 1) * (pr + 1));
			rd(ctm_pkg::OFS_IR);
			check(d & 32'h1, 32'h1);
		end
		// every external match action from both starting levels
		for (int j = 0; j < 8; j++) begin
			restart(32'h0, 32'h0);
			wr(ctm_pkg::OFS_MR0, 32'h3);
			wr(ctm_pkg::OFS_EMR, (j % 4) << 4 | j / 4);
			wr(ctm_pkg::OFS_TCR, 32'h0000_0001);
			wait_cycles(12);
			check(mat[0], emr_exp(j % 4, 1'(j / 4)));
		end
		// stop on match freezes the count and flags channel 1
		mr = $urandom_range(5, 40);
		restart(32'h0000_0028, 32'h0);
		wr(ctm_pkg::OFS_EMR, 32'h0);
		wr(ctm_pkg::OFS_MR0 + 8'h04, mr);
		wr(ctm_pkg::OFS_TCR, 32'h0000_0001);
		wait_cycles(mr + 8);
		rd(ctm_pkg::OFS_TCR);
		check(d & 32'h1, 32'h0);
		rd(ctm_pkg::OFS_TC);
		check(d, mr);
		rd(ctm_pkg::OFS_IR);
		check(d, 32'h2);
		wr(ctm_pkg::OFS_IR, 32'h2);
		rd(ctm_pkg::OFS_IR);
		check(d, 32'h0);
		// pwm: channel 3 sets the cycle, channels 0..2 pwm
		// channel 0 stays high long enough to be caught high below
		len = $urandom_range(8, 30);
		m = $urandom_range(1, len - 6);
		restart(32'h0000_0400, 32'h0);
		wr(ctm_pkg::OFS_MR0 + 8'h0C, len);
		wr(ctm_pkg::OFS_MR0, m);
		wr(ctm_pkg::OFS_MR0 + 8'h04, len);
		wr(ctm_pkg::OFS_MR0 + 8'h08, 32'h0);
		wr(ctm_pkg::OFS_PWM_SELECT_REG, 32'h7);
		wr(ctm_pkg::OFS_TCR, 32'h0000_0001);
		wait_cycles(2 * (len + 1));
		count_hi(2 * (len + 1));
		check(hc[0], 2 * (len + 1 - m));
		check(hc[1], 2);
		check(hc[2], 2 * (len + 1));
		check(hc[3], 0);
		g = 0;
		while (mat[0] !== 1'b1 && g < 100) begin
			@(posedge clk_i);
			g++;
		end
		wr(ctm_pkg::OFS_MR0, len + 5);
		wait_cycles(2 * (len + 1));
		count_hi(2 * (len + 1));
		check(hc[0], 0);
		// capture clears on the rising edge, loads on the falling edge
		w = $urandom_range(10, 60);
		restart(32'h0, 32'h0);
		wr(ctm_pkg::OFS_PWM_SELECT_REG, 32'h0);
		wr(ctm_pkg::OFS_CCR, 32'h6);
		wr(ctm_pkg::OFS_CTCR, 32'h10);
		wr(ctm_pkg::OFS_TCR, 32'h0000_0001);
		wait_cycles(40);
		pulses(1'b0, w, 4, 1);
		rd(ctm_pkg::OFS_CR0);
		check(d + 1 >= w && d <= w + 1, 1);
		rd(ctm_pkg::OFS_IR);
		check(d & 32'h10, 32'h10);
		// counter modes on the second capture pin
		for (int md = 1; md < 4; md++) begin
			n = $urandom_range(3, 20);
			restart(32'h0, 32'h0);
			wr(ctm_pkg::OFS_CCR, 32'h0);
			wr(ctm_pkg::OFS_CTCR, md | 32'h4);
			wr(ctm_pkg::OFS_TCR, 32'h0000_0001);
			pulses(1'b1, 3, 3, n);
			rd(ctm_pkg::OFS_TC);
			check(d, (md == 3) ? 2 * n : n);
		end
		tally_and_finish();
	end
endmodule
